// file: pel_consts.svh
// constants for the port eee lpi status and control block
// assumes a 16-bit host port with byte address and two byte enables
`ifndef PEL_CONSTS_SVH
`define PEL_CONSTS_SVH

// ======================================================
// register byte addresses
`define PEL_ADDR_W          8
`define PEL_OFF_STATUS      8'hE4
`define PEL_OFF_RECOVERY    8'hE6
`define PEL_OFF_BLCTRL      8'hE7

// ======================================================
// status register bit positions
`define PEL_B_RSVD15        15
`define PEL_B_HW_EEE        14
`define PEL_B_TX_LPI_SEEN   13
`define PEL_B_TX_LPI_LIVE   12
`define PEL_B_RX_LPI_SEEN   11
`define PEL_B_RX_LPI_LIVE   10
`define PEL_B_RSVD9         9
`define PEL_B_RSVD8         8
`define PEL_B_NP_LOC_ABLE   6
`define PEL_B_NP_LOC        5
`define PEL_B_PD_FAULT      4
`define PEL_B_LP_NP_ABLE    3
`define PEL_B_NP_ABLE       2
`define PEL_B_PAGE_RX       1
`define PEL_B_LP_AN_ABLE    0

// ======================================================
// control register fields and reset values
`define PEL_B_TRAFFIC_EN    7
`define PEL_THR_MSB         5
`define PEL_RST_RSVD15      1'h1
`define PEL_RST_RECOVERY    8'h27
`define PEL_RST_THRESHOLD   6'h08
`define PEL_USAGE_W         8

// ======================================================
// timing: one recovery unit is 640 ns, clock period 8 ns
`define PEL_UNIT_NS         640
`define PEL_CLK_NS          8
`define PEL_UNIT_CYC        ((`PEL_UNIT_NS + `PEL_CLK_NS - 1) / `PEL_CLK_NS)
`define PEL_UNIT_CNT_W      7

`endif

// file: pel_pkg.sv
// types for the port eee lpi status and control block
// assumes pel_consts.svh is not needed here
`default_nettype none
package pel_pkg;
   typedef enum logic [0:0] {
      PEL_REC_IDLE,
      PEL_REC_WAIT
   } pel_rec_state_t;
endpackage
`default_nettype wire

// file: pel_recovery_timer.sv
// lpi recovery wait timer: holds off transmission after leaving lpi
// assumes lpi_active is synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
`include "pel_consts.svh"

module pel_recovery_timer
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        lpi_active,
   input  wire logic [7:0]  recovery_units,
   output var  logic        tx_allowed_r
);

   pel_pkg::pel_rec_state_t            state_r, state_nxt;
   logic [`PEL_UNIT_CNT_W-1:0]         sub_r, sub_nxt;
   logic [7:0]                         units_r, units_nxt;
   logic                               lpi_d_r;
   logic                               tx_allowed_nxt;

   // ======================================================
   // next state
   always_comb
   begin
      state_nxt      = state_r;
      sub_nxt        = sub_r;
      units_nxt      = units_r;
      tx_allowed_nxt = tx_allowed_r;
      case (state_r)
         pel_pkg::PEL_REC_IDLE:
         begin
            tx_allowed_nxt = !lpi_active;
            // falling edge of lpi starts the wait, in 640 ns units
            if (lpi_d_r && !lpi_active && recovery_units != 8'h00)
            begin
               state_nxt      = pel_pkg::PEL_REC_WAIT;
               units_nxt      = recovery_units;
               sub_nxt        = `PEL_UNIT_CNT_W'(`PEL_UNIT_CYC - 1);
               tx_allowed_nxt = 1'b0;
            end
         end
         pel_pkg::PEL_REC_WAIT:
         begin
            tx_allowed_nxt = 1'b0;
            // re-entering lpi abandons the wait
            if (lpi_active)
               state_nxt = pel_pkg::PEL_REC_IDLE;
            else if (sub_r != `PEL_UNIT_CNT_W'(0))
               sub_nxt = sub_r - `PEL_UNIT_CNT_W'(1);
            else if (units_r == 8'h01)
            begin
               state_nxt      = pel_pkg::PEL_REC_IDLE;
               tx_allowed_nxt = 1'b1;
            end
            else
            begin
               units_nxt = units_r - 8'h01;
               sub_nxt   = `PEL_UNIT_CNT_W'(`PEL_UNIT_CYC - 1);
            end
         end
         default:
            state_nxt = pel_pkg::PEL_REC_IDLE;
      endcase
   end

   // ======================================================
   // registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r      <= pel_pkg::PEL_REC_IDLE;
         sub_r        <= '0;
         units_r      <= 8'h00;
         lpi_d_r      <= 1'b0;
         tx_allowed_r <= 1'b1;
      end
      else
      begin
         state_r      <= state_nxt;
         sub_r        <= sub_nxt;
         units_r      <= units_nxt;
         lpi_d_r      <= lpi_active;
         tx_allowed_r <= tx_allowed_nxt;
      end
   end

endmodule // pel_recovery_timer
`default_nettype wire

// file: pel_port_eee.sv
// port eee lpi status and control registers, with lpi termination
// assumes single-cycle host strobes synchronous to core_clk
//
// Overview of operation
// - A sticky rx-lpi-seen flag in bit 11 sets whenever the receive PCS reports lpi.
// - Writing one to bit 11 clears that flag unless lpi arrives in the same cycle.
// - Bit 10 reads the live receive lpi indication.
// - Bit 6 reads constant one, the next page location is specified.
// - Bit 5 reads constant one, the next page storage location is fixed.
// - Bit 4 latches a parallel detection fault and clears when the register is read.
// - Bit 3 reads one when the link partner is next page able.
// - Bit 2 reads one since the local device supports next pages.
// - Bit 1 latches when a new auto-negotiation page arrives.
// - Bit 0 reads one when the link partner can auto-negotiate.
// - After leaving lpi the MAC waits the programmed recovery time, reset 0x27.
// - Each recovery unit is 640 ns.
// - With bit 7 set, input traffic stops an active lpi request.
// - Buffer usage at or above the 6-bit threshold in 512-byte units stops lpi.
// - Bit 13 latches tx lpi and clears on write one; bit 12 shows live tx lpi.
`timescale 1ns/100ps
`default_nettype none
`include "pel_consts.svh"

module pel_port_eee
(
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   input  wire logic [`PEL_ADDR_W-1:0]  host_addr,
   input  wire logic [1:0]              host_be,
   input  wire logic                    host_wr,
   input  wire logic                    host_rd,
   input  wire logic [15:0]             host_wdata,
   output var  logic [15:0]             host_rdata_r,
   input  wire logic                    rx_lpi_active,
   input  wire logic                    tx_lpi_active,
   input  wire logic                    hw_eee_enabled,
   input  wire logic                    pd_fault_event,
   input  wire logic                    page_rx_event,
   input  wire logic                    lp_np_able,
   input  wire logic                    lp_an_able,
   input  wire logic                    lpi_req_in,
   input  wire logic                    input_traffic,
   input  wire logic [`PEL_USAGE_W-1:0] buffer_usage,
   output var  logic                    lpi_request_r,
   output var  logic                    tx_allowed_r
);

   logic                    rsvd15_r, rsvd15_nxt;
   logic [1:0]              rsvd98_r, rsvd98_nxt;
   logic                    rx_seen_r, rx_seen_nxt;
   logic                    tx_seen_r, tx_seen_nxt;
   logic                    pd_fault_r, pd_fault_nxt;
   logic                    page_rx_r, page_rx_nxt;
   logic [7:0]              recovery_r, recovery_nxt;
   logic                    traffic_en_r, traffic_en_nxt;
   logic [`PEL_THR_MSB:0]   threshold_r, threshold_nxt;
   logic [15:0]             rdata_nxt;
   logic [15:0]             status_word;
   logic                    lpi_request_nxt;
   logic                    wr_status;
   logic                    wr_lo;
   logic                    wr_hi;
   logic                    rd_status;

   // ======================================================
   // address decode; word access at even address
   function automatic logic hits(input logic [`PEL_ADDR_W-1:0] a,
                                 input logic [`PEL_ADDR_W-1:0] off);
      hits = (a[`PEL_ADDR_W-1:1] == off[`PEL_ADDR_W-1:1]);
   endfunction

   assign wr_status = host_wr && hits(host_addr, `PEL_OFF_STATUS);
   assign rd_status = host_rd && hits(host_addr, `PEL_OFF_STATUS);
   assign wr_lo     = host_wr && hits(host_addr, `PEL_OFF_RECOVERY) && host_be[0];
   assign wr_hi     = host_wr && hits(host_addr, `PEL_OFF_BLCTRL) && host_be[1];

   // ======================================================
   // status word assembly
   always_comb
   begin
      status_word                       = 16'h0000;
      status_word[`PEL_B_RSVD15]        = rsvd15_r;
      status_word[`PEL_B_HW_EEE]        = hw_eee_enabled;
      status_word[`PEL_B_TX_LPI_SEEN]   = tx_seen_r;
      status_word[`PEL_B_TX_LPI_LIVE]   = tx_lpi_active;
      status_word[`PEL_B_RX_LPI_SEEN]   = rx_seen_r;
      status_word[`PEL_B_RX_LPI_LIVE]   = rx_lpi_active;
      status_word[`PEL_B_RSVD9]         = rsvd98_r[1];
      status_word[`PEL_B_RSVD8]         = rsvd98_r[0];
      status_word[`PEL_B_NP_LOC_ABLE]   = 1'b1;
      status_word[`PEL_B_NP_LOC]        = 1'b1;
      status_word[`PEL_B_PD_FAULT]      = pd_fault_r;
      status_word[`PEL_B_LP_NP_ABLE]    = lp_np_able;
      status_word[`PEL_B_NP_ABLE]       = 1'b1;
      status_word[`PEL_B_PAGE_RX]       = page_rx_r;
      status_word[`PEL_B_LP_AN_ABLE]    = lp_an_able;
   end

   // ======================================================
   // register next values
   always_comb
   begin
      rsvd15_nxt     = rsvd15_r;
      rsvd98_nxt     = rsvd98_r;
      recovery_nxt   = recovery_r;
      traffic_en_nxt = traffic_en_r;
      threshold_nxt  = threshold_r;
      if (wr_status && host_be[1])
      begin
         rsvd15_nxt = host_wdata[`PEL_B_RSVD15];
         rsvd98_nxt = host_wdata[`PEL_B_RSVD9:`PEL_B_RSVD8];
      end
      if (wr_lo)
         recovery_nxt = host_wdata[7:0];
      if (wr_hi)
      begin
         traffic_en_nxt = host_wdata[8 + `PEL_B_TRAFFIC_EN];
         threshold_nxt  = host_wdata[8 + `PEL_THR_MSB:8];
      end
      // set wins over clear for every sticky flag
      rx_seen_nxt  = rx_lpi_active
                   || (rx_seen_r && !(wr_status && host_be[1]
                                      && host_wdata[`PEL_B_RX_LPI_SEEN]));
      tx_seen_nxt  = tx_lpi_active
                   || (tx_seen_r && !(wr_status && host_be[1]
                                      && host_wdata[`PEL_B_TX_LPI_SEEN]));
      pd_fault_nxt = pd_fault_event || (pd_fault_r && !rd_status);
      page_rx_nxt  = page_rx_event || (page_rx_r && !rd_status);
      // read data: unmapped addresses return zero
      rdata_nxt = host_rdata_r;
      if (host_rd)
      begin
         if (hits(host_addr, `PEL_OFF_STATUS))
            rdata_nxt = status_word;
         else if (hits(host_addr, `PEL_OFF_RECOVERY))
            rdata_nxt = {traffic_en_r, 1'b0, threshold_r, recovery_r};
         else
            rdata_nxt = 16'h0000;
      end
      // termination from traffic or from buffer load; usage in 512-byte units
      lpi_request_nxt = lpi_req_in
                      && !(traffic_en_r && input_traffic)
                      && !(buffer_usage >= {2'b00, threshold_r});
   end

   // ======================================================
   // registers
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rsvd15_r      <= `PEL_RST_RSVD15;
         rsvd98_r      <= 2'h0;
         rx_seen_r     <= 1'b0;
         tx_seen_r     <= 1'b0;
         pd_fault_r    <= 1'b0;
         page_rx_r     <= 1'b0;
         recovery_r    <= `PEL_RST_RECOVERY;
         traffic_en_r  <= 1'b0;
         threshold_r   <= `PEL_RST_THRESHOLD;
         host_rdata_r  <= 16'h0000;
         lpi_request_r <= 1'b0;
      end
      else
      begin
         rsvd15_r      <= rsvd15_nxt;
         rsvd98_r      <= rsvd98_nxt;
         rx_seen_r     <= rx_seen_nxt;
         tx_seen_r     <= tx_seen_nxt;
         pd_fault_r    <= pd_fault_nxt;
         page_rx_r     <= page_rx_nxt;
         recovery_r    <= recovery_nxt;
         traffic_en_r  <= traffic_en_nxt;
         threshold_r   <= threshold_nxt;
         host_rdata_r  <= rdata_nxt;
         lpi_request_r <= lpi_request_nxt;
      end
   end

   // ======================================================
   // recovery wait; a value of zero means no wait at all
   pel_recovery_timer u_recovery
   (
      .core_clk       (core_clk),
      .resetn         (resetn),
      .lpi_active     (tx_lpi_active),
      .recovery_units (recovery_r),
      .tx_allowed_r   (tx_allowed_r)
   );

endmodule // pel_port_eee
`default_nettype wire

// file: pel_port_eee_monitor.sv
// assertions on the host port and line-side outputs of pel_port_eee
// assumes a bind from the testbench top; sees only the top's ports
`timescale 1ns/100ps
`default_nettype none
`include "pel_consts.svh"
module pel_port_eee_monitor
(
   input wire logic                   core_clk,
   input wire logic                   resetn,
   input wire logic [`PEL_ADDR_W-1:0] host_addr,
   input wire logic [1:0]             host_be,
   input wire logic                   host_wr,
   input wire logic                   host_rd,
   input wire logic [15:0]            host_wdata,
   input wire logic [15:0]            host_rdata_r,
   input wire logic                   rx_lpi_active,
   input wire logic                   tx_lpi_active,
   input wire logic                   pd_fault_event,
   input wire logic                   page_rx_event,
   input wire logic                   lp_np_able,
   input wire logic                   lp_an_able,
   input wire logic                   tx_allowed_r
);
   // ======================================================
   // status reads
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic st_hit;
   logic pd_p_r;
   logic pg_p_r;
   assign st_hit = (host_addr | 8'h01) == 8'hE5;
   // pending events not yet consumed by a status read; set wins over the read
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         {pd_p_r, pg_p_r} <= 2'b00;
      else
         {pd_p_r, pg_p_r} <= {pd_fault_event, page_rx_event}
                              | ({pd_p_r, pg_p_r} & {2{!(host_rd && st_hit)}});
   end
   sequence s_rd;
      host_rd && st_hit;
   endsequence
   sequence s_clr11;
      host_wr && st_hit && host_be[1] && host_wdata[11] && !rx_lpi_active;
   endsequence
   sequence s_clr13;
      host_wr && st_hit && host_be[1] && host_wdata[13] && !tx_lpi_active;
   endsequence
   AST_CONST: assert property (s_rd |=> &{host_rdata_r[6:5], host_rdata_r[2]})
      else $error("status constant bits wrong");
   AST_LIVE: assert property (s_rd |=> host_rdata_r[10] == $past(rx_lpi_active))
      else $error("live rx lpi bit wrong");
   AST_NP: assert property (s_rd |=> host_rdata_r[3] == $past(lp_np_able))
      else $error("partner next page bit wrong");
   AST_AN: assert property (s_rd |=> host_rdata_r[0] == $past(lp_an_able))
      else $error("partner autoneg bit wrong");
   AST_SEEN: assert property (rx_lpi_active ##1 s_rd |=> host_rdata_r[11])
      else $error("rx lpi seen flag lost");
   AST_W1C: assert property (s_clr11 ##1 !rx_lpi_active ##1 s_rd ##0 !rx_lpi_active
      |=> !host_rdata_r[11]) else $error("rx lpi seen not cleared");
   AST_PD: assert property (s_rd |=> host_rdata_r[4] == $past(pd_p_r))
      else $error("parallel fault latch wrong");
   AST_PG: assert property (s_rd |=> host_rdata_r[1] == $past(pg_p_r))
      else $error("page received latch wrong");
   AST_TXW: assert property (tx_lpi_active |=> !tx_allowed_r)
      else $error("tx allowed during lpi");
   AST_TXLIVE: assert property (s_rd |=> host_rdata_r[12] == $past(tx_lpi_active))
      else $error("live tx lpi bit wrong");
   AST_TXCLR: assert property (s_clr13 ##1 !tx_lpi_active ##1 s_rd ##0 !tx_lpi_active
      |=> !host_rdata_r[13]) else $error("tx lpi seen not cleared");
   AST_HOLD: assert property (!host_rd |=> $stable(host_rdata_r))
      else $error("read data moved without read");
endmodule // pel_port_eee_monitor
`default_nettype wire

// file: pel_link_model.sv
// line-side model: pcs lpi levels and auto-negotiation events
// assumes cmd changes by non-blocking assignment; outputs move at falling edges
`timescale 1ns/100ps
`default_nettype none
module pel_link_model
(
   input  wire logic       core_clk,
   input  wire logic [5:0] cmd,
   output var  logic       rx_lpi_active,
   output var  logic       tx_lpi_active,
   output var  logic       pd_fault_event,
   output var  logic       page_rx_event,
   output var  logic       lp_np_able,
   output var  logic       lp_an_able
);
   // ======================================================
   // cmd: 0 rx lpi, 1 tx lpi, 2 np able, 3 an able, 4 fault, 5 page
   logic [5:0] cmd_q = 6'h00;
   initial {rx_lpi_active, tx_lpi_active, pd_fault_event, page_rx_event} = 4'h0;
   initial {lp_np_able, lp_an_able} = 2'h0;
   // events are one-cycle pulses on a rising cmd bit, as a real page arrival is
   always @(negedge core_clk)
   begin
      cmd_q <= cmd;
      {lp_an_able, lp_np_able, tx_lpi_active, rx_lpi_active} <= cmd[3:0];
      {page_rx_event, pd_fault_event} <= cmd[5:4] & ~cmd_q[5:4];
   end
endmodule // pel_link_model
`default_nettype wire

// file: testbench.sv
// top-level bench for pel_port_eee: host register tasks and line scenarios
// assumes pel_link_model drives the pcs and auto-negotiation inputs
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  host_addr = 8'h00;
   logic [1:0]  host_be = 2'h0;
   logic        host_wr = 1'b0, host_rd = 1'b0, hw_eee_enabled = 1'b0;
   logic [15:0] host_wdata = 16'h0000, host_rdata_r, rv;
   logic        lpi_req_in = 1'b0, input_traffic = 1'b0;
   logic [7:0]  buffer_usage = 8'h00;
   logic [5:0]  cmd = 6'h00;
   logic        rx_lpi_active, tx_lpi_active, pd_fault_event, page_rx_event;
   logic        lp_np_able, lp_an_able, lpi_request_r, tx_allowed_r;
   int          err_total = 0, checked = 0, cyc = 0;
   // ======================================================
   // clock, instances, shared tasks
   always #4 core_clk = ~core_clk;
   pel_port_eee dut (.core_clk, .resetn, .host_addr, .host_be, .host_wr, .host_rd,
      .host_wdata, .host_rdata_r, .rx_lpi_active, .tx_lpi_active, .hw_eee_enabled,
      .pd_fault_event, .page_rx_event, .lp_np_able, .lp_an_able, .lpi_req_in,
      .input_traffic, .buffer_usage, .lpi_request_r, .tx_allowed_r);
   pel_link_model link (.core_clk, .cmd, .rx_lpi_active, .tx_lpi_active,
      .pd_fault_event, .page_rx_event, .lp_np_able, .lp_an_able);
   task automatic end_sim;
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(negedge core_clk);
      {host_addr, host_be, host_wdata, host_wr} = {a, be, d, 1'b1};
      @(negedge core_clk);
      host_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge core_clk);
      {host_addr, host_rd} = {a, 1'b1};
      @(negedge core_clk);
      host_rd = 1'b0;
      rv = host_rdata_r;
   endtask
   // ======================================================
   // scenarios
   task automatic t_defaults;
      rd(8'hE4);
      chk(rv, 16'h8064);
      rd(8'hE6);
      chk(rv, 16'h0827);
      rd(8'hE8);
      chk(rv, 16'h0000);
      // low byte of the status word is read-only; high byte holds the stored bits
      wr(8'hE4, 2'h1, 16'h8B00);
      rd(8'hE4);
      chk(rv, 16'h8064);
      wr(8'hE4, 2'h2, 16'h0300);
      rd(8'hE4);
      chk(rv, 16'h0364);
      wr(8'hE4, 2'h2, 16'h8000);
   endtask
   task automatic t_rx_lpi;
      cmd <= 6'h01;
      step(3);
      rd(8'hE4);
      chk(rv, 16'h8C64);
      cmd <= 6'h00;
      step(3);
      rd(8'hE4);
      chk(rv, 16'h8864);
      wr(8'hE4, 2'h2, 16'h8800);
      rd(8'hE4);
      chk(rv, 16'h8064);
   endtask
   // two back-to-back reads: the second must see the latches already cleared
   task automatic t_an_flags;
      cmd <= 6'h3C;
      hw_eee_enabled = 1'b1;
      step(4);
      {host_addr, host_rd} = {8'hE4, 1'b1};
      step(1);
      rv = host_rdata_r;
      step(1);
      host_rd = 1'b0;
      chk(rv, 16'hC07F);
      chk(host_rdata_r, 16'hC06D);
      cmd <= 6'h00;
      hw_eee_enabled = 1'b0;
   endtask
   task automatic t_lpi_req;
      wr(8'hE6, 2'h3, 16'h8402);
      {lpi_req_in, buffer_usage} = {1'b1, 8'h03};
      step(2);
      chk({15'h0, lpi_request_r}, 16'h0001);
      input_traffic = 1'b1;
      step(2);
      chk({15'h0, lpi_request_r}, 16'h0000);
      wr(8'hE7, 2'h2, 16'h0400);
      step(1);
      chk({15'h0, lpi_request_r}, 16'h0001);
      buffer_usage = 8'h04;
      step(2);
      chk({15'h0, lpi_request_r}, 16'h0000);
      rd(8'hE6);
      chk(rv, 16'h0402);
      {lpi_req_in, input_traffic} = 2'b00;
   endtask
   // recovery is 2 units here, so the wait is 160 cycles of 8 ns
   task automatic t_recovery;
      int n = 0;
      cmd <= 6'h02;
      step(2);
      chk({15'h0, tx_allowed_r}, 16'h0000);
      rd(8'hE4);
      chk(rv, 16'hB064);
      cmd <= 6'h00;
      step(2);
      while (!tx_allowed_r && n < 400)
      begin
         step(1);
         n++;
      end
      chk({15'h0, (n >= 158 && n <= 162)}, 16'h0001);
      wr(8'hE4, 2'h2, 16'hA000);
      rd(8'hE4);
      chk(rv, 16'h8064);
   endtask
   initial
   begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      t_defaults;
      t_rx_lpi;
      t_an_flags;
      t_lpi_req;
      t_recovery;
      end_sim;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         end_sim;
      end
   end
endmodule // testbench
bind pel_port_eee pel_port_eee_monitor mon (.core_clk, .resetn, .host_addr, .host_be,
   .host_wr, .host_rd, .host_wdata, .host_rdata_r, .rx_lpi_active, .tx_lpi_active,
   .pd_fault_event, .page_rx_event, .lp_np_able, .lp_an_able, .tx_allowed_r);
`default_nettype wire
